//--- verilog/iic_pkg.sv
package iic_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL1    = 8'h14;
  localparam logic [7:0] ADDR_RELOAD   = 8'h18;
  localparam logic [7:0] ADDR_BUF      = 8'h1C;
  localparam logic [7:0] ADDR_STATUS   = 8'h20;
  localparam logic [7:0] ADDR_INT_STAT = 8'h24;
  localparam logic [7:0] ADDR_INT_MASK = 8'h28;
  localparam logic [7:0] ADDR_FW_DRIVE = 8'h2C;

  // control one field positions
  localparam int CTRL_WRITE_COLLISION_FLAG = 7;
  localparam int CTRL_OVF  = 6;
  localparam int CTRL_EN   = 5;
  localparam int CTRL_CKP  = 4;

  // firmware drive field positions
  localparam int FW_SCL_LOW = 0;
  localparam int FW_SDA_LOW = 1;

  // interrupt status / mask field positions
  localparam int INT_BYTE  = 0;
  localparam int INT_START = 1;
  localparam int INT_STOP  = 2;
  localparam int INT_OVF   = 3;
  localparam int INT_WRITE_COLLISION_FLAG  = 4;
  localparam int INT_W     = 5;

  // port mode field encodings
  localparam logic [3:0] MODE_SLV10_SS = 4'hF;
  localparam logic [3:0] MODE_SLV7_SS  = 4'hE;
  localparam logic [3:0] MODE_FW_MSTR  = 4'hB;
  localparam logic [3:0] MODE_MASTER   = 4'h8;
  localparam logic [3:0] MODE_SLV10    = 4'h7;
  localparam logic [3:0] MODE_SLV7     = 4'h6;

  // values after reset
  localparam logic [7:0]     CTRL1_RST    = 8'h00;
  localparam logic [7:0]     RELOAD_RST   = 8'h00;
  localparam logic [INT_W-1:0] INT_RST    = 5'h00;
  localparam logic [1:0]     FW_RST       = 2'h0;

  // scl period is 4*(reload+1) pclk cycles, so one half is 2*(reload+1)
  localparam int SCL_HALF_MULT = 2;
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

  typedef enum logic [1:0] {
    IIC_M_IDLE = 2'b00,
    IIC_M_LOW  = 2'b01,
    IIC_M_HIGH = 2'b10
  } iic_mstate_t;

endpackage

//--- verilog/iic_line_mon.sv
`timescale 1ns/100ps
module iic_line_mon (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_s,
  output logic      sda_s,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_det,
  output logic      stop_det
);

  logic [1:0] scl_meta;
  logic [1:0] sda_meta;
  logic       scl_d;
  logic       sda_d;

  // idle bus is high, so the chain resets high to avoid a false edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_meta <= 2'h3;
      sda_meta <= 2'h3;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
    end else begin
      scl_meta <= {scl_meta[0], scl_in};
      sda_meta <= {sda_meta[0], sda_in};
      scl_d    <= scl_meta[1];
      sda_d    <= sda_meta[1];
    end
  end

  assign scl_s     = scl_meta[1];
  assign sda_s     = sda_meta[1];
  assign scl_rise  = scl_meta[1] & ~scl_d;
  assign scl_fall  = ~scl_meta[1] & scl_d;
  assign start_det = scl_meta[1] & scl_d & sda_d & ~sda_meta[1];
  assign stop_det  = scl_meta[1] & scl_d & ~sda_d & sda_meta[1];

endmodule

//--- verilog/iic_ctrl.sv
// Decided for this implementation: the APB register port.
`timescale 1ns/100ps
module iic_ctrl
  import iic_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             port_active,
  output logic             irq
);

  logic [7:0]       ctrl1;
  logic [7:0]       reload;
  logic [INT_W-1:0] int_stat;
  logic [INT_W-1:0] int_mask;
  logic [1:0]       fw_drive;
  logic [7:0]       rx_buf;
  logic             rx_full;
  logic [7:0]       rx_shift;
  logic [3:0]       rx_bits;
  logic             slv_ack;
  logic             start_last;
  logic             stop_last;
  logic [7:0]       tx_shift;
  logic [3:0]       tx_bits;
  logic [8:0]       div_cnt;
  iic_mstate_t      mstate;
  iic_mstate_t      next_mstate;

  logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
  iic_line_mon u_mon (
    .pclk      (pclk),
    .presetn   (presetn),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .scl_s     (scl_s),
    .sda_s     (sda_s),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det)
  );
  logic [3:0] mode;
  logic       en;
  logic       slv_mode;
  logic       ss_irq_mode;
  logic       mst_mode;
  logic       fw_mode;
  assign mode        = ctrl1[3:0];
  assign en          = ctrl1[CTRL_EN];
  assign ss_irq_mode = (mode == MODE_SLV10_SS) | (mode == MODE_SLV7_SS);
  assign slv_mode    = en & (ss_irq_mode | (mode == MODE_SLV10) |
                             (mode == MODE_SLV7));
  assign mst_mode    = en & (mode == MODE_MASTER);
  assign fw_mode     = en & (mode == MODE_FW_MSTR);
  logic bus_wr;
  logic bus_rd;
  logic addr_ok;
  assign pready  = 1'b1;
  assign addr_ok = (paddr == ADDR_CTRL1) | (paddr == ADDR_RELOAD) |
                   (paddr == ADDR_BUF) | (paddr == ADDR_STATUS) |
                   (paddr == ADDR_INT_STAT) | (paddr == ADDR_INT_MASK) |
                   (paddr == ADDR_FW_DRIVE);
  assign pslverr = psel & penable & ~addr_ok;
  assign bus_wr  = psel & penable & pwrite & addr_ok;
  assign bus_rd  = psel & penable & ~pwrite & addr_ok;
  // read data is captured in the setup cycle so it leaves a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      case (paddr)
        ADDR_CTRL1:    prdata <= {24'h000000, ctrl1};
        ADDR_RELOAD:   prdata <= {24'h000000, reload};
        ADDR_BUF:      prdata <= {24'h000000, rx_buf};
        ADDR_STATUS:   prdata <= {26'h0000000, sda_s, scl_s, stop_last,
                                  start_last, (mstate != IIC_M_IDLE),
                                  rx_full};
        ADDR_INT_STAT: prdata <= {27'h0000000, int_stat};
        ADDR_INT_MASK: prdata <= {27'h0000000, int_mask};
        ADDR_FW_DRIVE: prdata <= {30'h00000000, fw_drive};
        default:       prdata <= 32'h0000_0000;
      endcase
    end
  end
  logic buf_wr;
  logic tx_busy;
  logic write_collision_flag_set;
  logic tx_load;
  logic byte_rx;
  logic ovf_set;
  logic byte_tx_done;
  logic ss_start;
  logic ss_stop;
  logic half_done;
  assign buf_wr   = bus_wr & (paddr == ADDR_BUF);
  assign tx_busy  = (mstate != IIC_M_IDLE) |
                    (slv_mode & (rx_bits != 4'h0));
  assign write_collision_flag_set = buf_wr & tx_busy;
  assign tx_load  = buf_wr & ~tx_busy & mst_mode;
  assign byte_rx  = slv_mode & scl_rise & (rx_bits == BITS_PER_BYTE - 4'h1);
  assign ovf_set  = byte_rx & rx_full;
  assign ss_start = slv_mode & ss_irq_mode & start_det;
  assign ss_stop  = slv_mode & ss_irq_mode & stop_det;
  assign byte_tx_done = (mstate == IIC_M_HIGH) & half_done &
                        (tx_bits == BITS_PER_BYTE);
  // hardware set of a flag wins over a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1 <= CTRL1_RST;
    end else begin
      if (bus_wr && paddr == ADDR_CTRL1) begin
        ctrl1 <= pwdata[7:0];
      end
      if (write_collision_flag_set) begin
        ctrl1[CTRL_WRITE_COLLISION_FLAG] <= 1'b1;
      end
      if (ovf_set) begin
        ctrl1[CTRL_OVF] <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload   <= RELOAD_RST;
      int_mask <= INT_RST;
      fw_drive <= FW_RST;
    end else if (bus_wr) begin
      case (paddr)
        ADDR_RELOAD:   reload   <= pwdata[7:0];
        ADDR_INT_MASK: int_mask <= pwdata[INT_W-1:0];
        ADDR_FW_DRIVE: fw_drive <= pwdata[1:0];
        default:       reload   <= reload;
      endcase
    end
  end

  logic [INT_W-1:0] int_set;
  logic [INT_W-1:0] int_clr;
  always_comb begin
    int_set            = INT_RST;
    int_set[INT_BYTE]  = (byte_rx & ~rx_full) | byte_tx_done;
    int_set[INT_START] = ss_start;
    int_set[INT_STOP]  = ss_stop;
    int_set[INT_OVF]   = ovf_set;
    int_set[INT_WRITE_COLLISION_FLAG]  = write_collision_flag_set;
  end

  assign int_clr = (bus_wr && paddr == ADDR_INT_STAT) ?
                   pwdata[INT_W-1:0] : INT_RST;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat <= INT_RST;
    end else begin
      int_stat <= int_set | (int_stat & ~int_clr);
    end
  end

  assign irq = |(int_stat & int_mask);
  // a disabled port forgets bus history so re-enabling starts clean
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_last <= 1'b0;
      stop_last  <= 1'b0;
    end else if (!en) begin
      start_last <= 1'b0;
      stop_last  <= 1'b0;
    end else if (start_det) begin
      start_last <= 1'b1;
      stop_last  <= 1'b0;
    end else if (stop_det) begin
      start_last <= 1'b0;
      stop_last  <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_shift <= 8'h00;
      rx_bits  <= 4'h0;
      slv_ack  <= 1'b0;
    end else if (!slv_mode || start_det || stop_det) begin
      rx_bits  <= 4'h0;
      slv_ack  <= 1'b0;
    end else begin
      if (scl_rise) begin
        rx_shift <= {rx_shift[6:0], sda_s};
        rx_bits  <= (rx_bits == BITS_PER_BYTE) ? 4'h0 : rx_bits + 4'h1;
      end
      // acknowledge is driven from the scl fall after the eighth bit until the fall after the ninth clock
      if (scl_fall) begin
        slv_ack <= (rx_bits == BITS_PER_BYTE);
      end
    end
  end

  // an overflowing byte is dropped: the unread byte stays intact
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buf  <= 8'h00;
      rx_full <= 1'b0;
    end else if (byte_rx && !rx_full) begin
      rx_buf  <= {rx_shift[6:0], sda_s};
      rx_full <= 1'b1;
    end else if (bus_rd && paddr == ADDR_BUF) begin
      rx_full <= 1'b0;
    end
  end
  logic [8:0] half_last;
  assign half_last = 9'(SCL_HALF_MULT) * ({1'b0, reload} + 9'h001) - 9'h001;
  assign half_done = (div_cnt == half_last);
  always_comb begin
    next_mstate = mstate;
    case (mstate)
      IIC_M_IDLE: if (tx_load) next_mstate = IIC_M_LOW;
      IIC_M_LOW:  if (half_done) next_mstate = IIC_M_HIGH;
      IIC_M_HIGH: begin
        if (half_done) begin
          next_mstate = (tx_bits == BITS_PER_BYTE) ? IIC_M_IDLE : IIC_M_LOW;
        end
      end
      default:    next_mstate = IIC_M_IDLE;
    endcase
    if (!mst_mode) begin
      next_mstate = IIC_M_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mstate <= IIC_M_IDLE;
    end else begin
      mstate <= next_mstate;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 9'h000;
    end else if (mstate == IIC_M_IDLE || half_done) begin
      div_cnt <= 9'h000;
    end else begin
      div_cnt <= div_cnt + 9'h001;
    end
  end

  // ninth clock leaves sda released for the receiver's acknowledge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_shift <= 8'hFF;
      tx_bits  <= 4'h0;
    end else if (tx_load) begin
      tx_shift <= pwdata[7:0];
      tx_bits  <= 4'h0;
    end else if (mstate == IIC_M_HIGH && half_done) begin
      tx_shift <= {tx_shift[6:0], 1'b1};
      tx_bits  <= tx_bits + 4'h1;
    end
  end
  // open drain: outputs stay low, enables pull the lines down
  // master terms are gated by the mode so a disable frees the pins at once
  assign scl_out     = 1'b0;
  assign sda_out     = 1'b0;
  assign port_active = en;
  assign scl_oe = (slv_mode & ~ctrl1[CTRL_CKP]) |
                  (mst_mode & (mstate == IIC_M_LOW)) |
                  (fw_mode & fw_drive[FW_SCL_LOW]);
  assign sda_oe = (slv_mode & slv_ack) |
                  (mst_mode & (mstate != IIC_M_IDLE) & ~tx_shift[7] &
                   (tx_bits != BITS_PER_BYTE)) |
                  (fw_mode & fw_drive[FW_SDA_LOW]);

endmodule

//--- bench/iic_ctrl_assertions.sv
`timescale 1ns/100ps
module iic_ctrl_assertions
  import iic_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        scl_oe,
  input wire logic        sda_oe,
  input wire logic        port_active
);
  logic [7:0] ctl_s;
  logic [7:0] rl_s;
  logic [1:0] fw_s;
  logic       last_oe;
  int         run;
  logic       slv;
  // all four slave encodings share ones in bits 2:1
  assign slv = ctl_s[2:1] == 2'b11;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_s <= CTRL1_RST;
      rl_s <= RELOAD_RST;
      fw_s <= FW_RST;
    end else if (psel && penable && pwrite) begin
      if (paddr == ADDR_CTRL1)
        ctl_s <= pwdata[7:0];
      if (paddr == ADDR_RELOAD)
        rl_s <= pwdata[7:0];
      if (paddr == ADDR_FW_DRIVE)
        fw_s <= pwdata[1:0];
    end
  end
  // length of the current scl_oe run, pulled or released, in pclk cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_oe <= 1'b0;
      run <= 0;
    end else if (scl_oe != last_oe) begin
      last_oe <= scl_oe;
      run <= 1;
    end else
      run <= run + 1;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_no_wait: assert property (psel && penable |-> pready)
    else $error("pready low in access");
  a_mapped_ok: assert property (psel && penable && paddr == ADDR_CTRL1
    |-> !pslverr) else $error("error on control one");
  a_unmapped_err: assert property (psel && penable && paddr > ADDR_FW_DRIVE
    |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped not refused");
  a_enable_track: assert property (port_active == ctl_s[CTRL_EN])
    else $error("port_active differs from enable");
  a_pins_released: assert property (!port_active |-> !scl_oe && !sda_oe)
    else $error("pins driven while off");
  a_stretch_hold: assert property (port_active && slv |->
    scl_oe == !ctl_s[CTRL_CKP]) else $error("scl hold wrong");
  a_fw_drive: assert property (port_active && ctl_s[3:0] == MODE_FW_MSTR
    |-> scl_oe == fw_s[FW_SCL_LOW] && sda_oe == fw_s[FW_SDA_LOW])
    else $error("firmware drive mismatch");
  a_master_half: assert property (ctl_s[3:0] == MODE_MASTER && last_oe
    && !scl_oe |-> run == SCL_HALF_MULT * (rl_s + 1))
    else $error("scl low phase length");
endmodule
bind iic_ctrl iic_ctrl_assertions iic_ctrl_assertions_i (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .scl_oe, .sda_oe, .port_active);

//--- bench/iic_bus_model.sv
`timescale 1ns/100ps
module iic_bus_model (
  input  wire logic clk,
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  logic        m_scl_low = 1'b0;
  logic        m_sda_low = 1'b0;
  logic [15:0] seen = 16'h0000;
  // pull-ups: a released line reads high
  assign scl = ~(scl_oe | m_scl_low);
  assign sda = ~(sda_oe | m_sda_low);
  always @(posedge scl)
    seen <= {seen[14:0], sda};
  task automatic gap;
    repeat (6) @(posedge clk);
  endtask
  task automatic sda_to(input logic low);
    m_sda_low <= low;
    gap();
  endtask
  // msb first, ninth clock left free for the acknowledge
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= -1; i--) begin
      m_scl_low <= 1'b1;
      gap();
      m_sda_low <= (i >= 0) ? ~b[i] : 1'b0;
      gap();
      m_scl_low <= 1'b0;
      gap();
    end
  endtask
endmodule

//--- bench/i2c_port_control_register_tb_top.sv
`timescale 1ns/100ps
module i2c_port_control_register_tb_top
  import iic_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        scl;
  logic        sda;
  logic        scl_oe;
  logic        sda_oe;
  logic        scl_out;
  logic        sda_out;
  logic        port_active;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  b;
  logic [7:0]  rxq[$];
  logic [3:0]  modes[6] = '{4'hF, 4'hE, 4'hB, 4'h8, 4'h7, 4'h6};
  int          failures = 0;
  int          n_compared = 0;
  int          k;
  always #2 pclk = ~pclk;
  iic_ctrl iic_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .scl_in(scl), .scl_out,
    .scl_oe, .sda_in(sda), .sda_out, .sda_oe, .port_active, .irq);
  iic_bus_model iic_bus_model_i (.clk(pclk), .scl_oe, .sda_oe, .scl, .sda);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    if (pready !== 1'b1) begin
      failures++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdx(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic wait_irq;
    for (k = 0; irq !== 1'b1; k++) begin
      if (k > 2000) begin
        failures++;
        end_sim();
      end
      @(posedge pclk);
    end
  endtask
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    b = 8'($urandom(32'h449F3C45));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdx(ADDR_CTRL1, CTRL1_RST);
    apb(1'b0, 8'h40, 32'h0);
    chk(err, 1'b1);
    foreach (modes[i]) begin
      apb(1'b1, ADDR_CTRL1, {26'h0, 2'b11, modes[i]});
      rdx(ADDR_CTRL1, {26'h0, 2'b11, modes[i]});
      chk(port_active, 1'b1);
    end
    apb(1'b1, ADDR_RELOAD, $urandom % 4);
    apb(1'b1, ADDR_INT_MASK, 32'h1);
    apb(1'b1, ADDR_CTRL1, 32'h28);
    b = 8'($urandom);
    apb(1'b1, ADDR_BUF, {24'h0, b});
    // second write lands while the first byte is still shifting
    apb(1'b1, ADDR_BUF, {24'h0, ~b});
    rdx(ADDR_CTRL1, 32'hA8);
    wait_irq();
    chk(iic_bus_model_i.seen[8:0], {b, 1'b1});
    rdx(ADDR_INT_STAT, 32'h11);
    apb(1'b1, ADDR_INT_STAT, 32'h1F);
    chk(irq, 1'b0);
    apb(1'b1, ADDR_CTRL1, 32'h2B);
    b = 8'($urandom % 4);
    apb(1'b1, ADDR_FW_DRIVE, {30'h0, b[1:0]});
    chk({scl, sda}, {~b[0], ~b[1]});
    chk({scl_out, sda_out}, 2'b00);
    apb(1'b1, ADDR_FW_DRIVE, 32'h0);
    apb(1'b1, ADDR_INT_MASK, 32'h6);
    foreach (modes[i]) begin
      if (modes[i][2]) begin
        apb(1'b1, ADDR_CTRL1, {26'h0, 2'b11, modes[i]});
        iic_bus_model_i.sda_to(1'b1);
        iic_bus_model_i.sda_to(1'b0);
        rdx(ADDR_INT_STAT, modes[i][3] ? 32'h6 : 32'h0);
        chk(irq, modes[i][3]);
        apb(1'b1, ADDR_INT_STAT, 32'h1F);
      end
    end
    apb(1'b1, ADDR_CTRL1, 32'h3E);
    iic_bus_model_i.sda_to(1'b1);
    b = 8'($urandom);
    rxq.push_back(b);
    iic_bus_model_i.send_byte(b);
    iic_bus_model_i.send_byte(~b);
    rdx(ADDR_CTRL1, 32'h7E);
    rdx(ADDR_BUF, rxq.pop_front());
    rdx(ADDR_INT_STAT, 32'hB);
    apb(1'b1, ADDR_CTRL1, 32'h2E);
    chk(scl, 1'b0);
    apb(1'b1, ADDR_CTRL1, 32'h3E);
    chk(scl, 1'b1);
    apb(1'b1, ADDR_CTRL1, 32'h0E);
    chk({port_active, scl, sda}, 3'b011);
    end_sim();
  end
endmodule
